// *** logic/spwd_pkg.sv ***
// constants and types for the standalone pin watchdog
`default_nettype none

package spwd_pkg;

  // internal time base
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // four build-time timeout selections, in microseconds
  localparam int unsigned TMO_3P4_US = 3_400;
  localparam int unsigned TMO_6P3_US = 6_300;
  localparam int unsigned TMO_102_US = 102_000;
  localparam int unsigned TMO_1P6_US = 1_600_000;

  localparam int unsigned TMO_3P4_CYC = TMO_3P4_US * CYC_PER_US;
  localparam int unsigned TMO_6P3_CYC = TMO_6P3_US * CYC_PER_US;
  localparam int unsigned TMO_102_CYC = TMO_102_US * CYC_PER_US;
  localparam int unsigned TMO_1P6_CYC = TMO_1P6_US * CYC_PER_US;

  // shortest alarm low pulse
  localparam int unsigned MIN_LOW_US  = 10;
  localparam int unsigned MIN_LOW_CYC = MIN_LOW_US * CYC_PER_US;

  // alarm pulse width of the both-edge variants, plain default
  localparam int unsigned PULSE_US       = 100;
  localparam int unsigned PULSE_DFLT_CYC = PULSE_US * CYC_PER_US;

  // input glitch filter: above 100 ns, below 1 us
  localparam int unsigned FILT_NS  = 500;
  localparam int unsigned FILT_CYC = FILT_NS * CYC_PER_US / 1000;
  localparam int unsigned FCW      = 8;

  // timeout counter width, holds the 1.6 s count
  localparam int unsigned CW = 29;

  localparam int unsigned IN_KICK = 0;
  localparam int unsigned IN_HOLD = 1;

  typedef enum logic [1:0] {
    SPWD_TMO_3P4MS = 2'b00,
    SPWD_TMO_6P3MS = 2'b01,
    SPWD_TMO_102MS = 2'b10,
    SPWD_TMO_1P6S  = 2'b11
  } spwd_tmo_t;

  typedef enum logic [0:0] {
    SPWD_ST_WATCH = 1'b0,
    SPWD_ST_ALARM = 1'b1
  } spwd_state_t;

  // sampled pins travel together
  typedef struct packed {
    logic hold;
    logic kick;
  } spwd_pins_t;

  function automatic int unsigned tmo_cycles(spwd_tmo_t sel);
    int unsigned c;
    c = TMO_3P4_CYC;
    case (sel)
      SPWD_TMO_6P3MS: c = TMO_6P3_CYC;
      SPWD_TMO_102MS: c = TMO_102_CYC;
      SPWD_TMO_1P6S:  c = TMO_1P6_CYC;
      default:        c = TMO_3P4_CYC;
    endcase
    return c;
  endfunction

endpackage

`default_nettype wire

// *** logic/spwd_top.sv ***
// standalone pin watchdog: kick filter, timeout counter, alarm output
// Operation
// - timeout is one of four build choices
// - controller kicks before timeout, else alarm asserts
// - every alarm transition clears the counter
// - hold-off pulse clears the counter
// - rising kick clears; falling only both-edge
// - kick pulses 1 us seen, 100 ns ignored
// - constant kick makes alarm toggle repeatedly
// - counting starts at power-up, alarm on timeout
// - both-edge alarm lasts full pulse width
// - rising-only alarm lasts 10 us to timeout
// - alarm output is active low
// - supervision only while hold-off is low
// - early hold-off delays alarm by hold plus timeout
// - hold-off releases alarm, low at least 10 us
// - hold-off pulses 1 us seen, 100 ns ignored
// - kick level ignored at power-up
`default_nettype none

module spwd_top #(
  parameter spwd_pkg::spwd_tmo_t TMO_SEL = spwd_pkg::SPWD_TMO_3P4MS,
  parameter int unsigned TIMEOUT_CYC = spwd_pkg::tmo_cycles(TMO_SEL),
  parameter int unsigned PULSE_CYC   = spwd_pkg::PULSE_DFLT_CYC,
  parameter bit          BOTH_EDGE   = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic kick_in,
  input  wire logic hold_in,
  output logic      alarm_out_n
);

  localparam int unsigned CW  = spwd_pkg::CW;
  localparam int unsigned FCW = spwd_pkg::FCW;

  localparam logic [CW-1:0] TMO_M1   = CW'(TIMEOUT_CYC - 1);
  localparam logic [CW-1:0] PULSE_M1 = CW'(PULSE_CYC - 1);
  localparam logic [CW-1:0] LOW_M1   = CW'(spwd_pkg::MIN_LOW_CYC - 1);
  localparam logic [FCW-1:0] FILT_M1 = FCW'(spwd_pkg::FILT_CYC - 1);

  spwd_pkg::spwd_pins_t pins;
  spwd_pkg::spwd_pins_t s1_q;
  spwd_pkg::spwd_pins_t s2_q;

  logic [1:0]     flt_q;
  logic [1:0]     prev_q;
  logic [1:0]     rdy_q;
  logic [1:0]     arm_q;
  logic [1:0]     rise;
  logic [1:0]     fall;
  logic [FCW-1:0] fc_q [2];

  assign pins.kick = kick_in;
  assign pins.hold = hold_in;

  // two-stage synchroniser; first stage read only by the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_flt
      logic           smp;
      logic           diff;
      logic           hit;
      logic [FCW-1:0] fc_d;

      assign smp  = s2_q[gi];
      assign diff = smp != flt_q[gi];
      assign hit  = fc_q[gi] == FILT_M1;
      // a level must hold FILT_CYC cycles before it is taken
      assign fc_d = (hit || (rdy_q[gi] && !diff)) ? '0
                  : fc_q[gi] + FCW'(1);

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          fc_q[gi]   <= '0;
          flt_q[gi]  <= 1'b0;
          rdy_q[gi]  <= 1'b0;
          arm_q[gi]  <= 1'b0;
          prev_q[gi] <= 1'b0;
        end else begin
          fc_q[gi]   <= fc_d;
          arm_q[gi]  <= rdy_q[gi];
          prev_q[gi] <= flt_q[gi];
          if (!rdy_q[gi]) begin
            // settle phase: track the pin, report no edges
            flt_q[gi] <= smp;
            if (hit) begin
              rdy_q[gi] <= 1'b1;
            end
          end else if (hit) begin
            flt_q[gi] <= smp;
          end
        end
      end

      assign rise[gi] = arm_q[gi] && flt_q[gi] && !prev_q[gi];
      assign fall[gi] = arm_q[gi] && !flt_q[gi] && prev_q[gi];
    end
  endgenerate

  logic hold;
  logic kick_rise;
  logic kick_ev;

  assign hold      = flt_q[spwd_pkg::IN_HOLD];
  assign kick_rise = rise[spwd_pkg::IN_KICK];
  assign kick_ev   = kick_rise
                   || (BOTH_EDGE && fall[spwd_pkg::IN_KICK]);

  spwd_pkg::spwd_state_t st_q;
  spwd_pkg::spwd_state_t st_d;
  logic [CW-1:0]         cnt_q;
  logic [CW-1:0]         cnt_d;
  logic                  alarm_n_q;
  logic                  alarm_n_d;
  logic                  watching;
  logic                  tmo_hit;
  logic                  low_ok;
  logic                  pulse_hit;
  logic                  go_alarm;
  logic                  rel_ok;
  logic                  wd_clr;

  assign watching  = st_q == spwd_pkg::SPWD_ST_WATCH;
  assign tmo_hit   = cnt_q == TMO_M1;
  assign low_ok    = cnt_q >= LOW_M1;
  assign pulse_hit = cnt_q == PULSE_M1;

  // hold-off and kicks clear; counter restarts afresh
  assign wd_clr   = hold || kick_ev;
  assign go_alarm = watching && !wd_clr && tmo_hit;

  // hold-off may cut the alarm short, never below 10 us;
  // both-edge ignores kicks while the pulse runs
  assign rel_ok = hold ? low_ok
                : BOTH_EDGE ? pulse_hit
                : (tmo_hit || (kick_rise && low_ok));

  assign st_d = watching
              ? (go_alarm ? spwd_pkg::SPWD_ST_ALARM
                          : spwd_pkg::SPWD_ST_WATCH)
              : (rel_ok ? spwd_pkg::SPWD_ST_WATCH
                        : spwd_pkg::SPWD_ST_ALARM);

  // any alarm edge restarts the count
  assign cnt_d = watching
               ? ((wd_clr || tmo_hit) ? '0 : cnt_q + CW'(1))
               : (rel_ok ? '0 : cnt_q + CW'(1));

  assign alarm_n_d = st_d != spwd_pkg::SPWD_ST_ALARM;

  // counter runs from reset release without any kick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q      <= spwd_pkg::SPWD_ST_WATCH;
      cnt_q     <= '0;
      alarm_n_q <= 1'b1;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      alarm_n_q <= alarm_n_d;
    end
  end

  assign alarm_out_n = alarm_n_q;

  // alarm only after a full uncleared period
  AST_ALARM_AT_TIMEOUT: assert property (
    @(posedge clock) disable iff (rst)
    $fell(alarm_n_q) |-> $past(cnt_q) == TMO_M1 && !$past(hold))
    else $error("alarm asserted before timeout");

  AST_EDGE_CLEARS: assert property (
    @(posedge clock) disable iff (rst)
    $changed(alarm_n_q) |-> cnt_q == '0 ##1 cnt_q <= CW'(1))
    else $error("alarm edge did not restart count");

  AST_HOLD_SUSPENDS: assert property (
    @(posedge clock) disable iff (rst)
    (watching && hold) |=> (cnt_q == '0 && alarm_n_q))
    else $error("hold-off did not clear the count");

  AST_RISE_CLEARS: assert property (
    @(posedge clock) disable iff (rst)
    (watching && kick_rise) |=> (cnt_q == '0 && alarm_n_q))
    else $error("rising kick did not clear the count");

  AST_FALL_IGNORED: assert property (
    @(posedge clock) disable iff (rst)
    (!BOTH_EDGE && watching && fall[spwd_pkg::IN_KICK] && !hold
     && !tmo_hit) |=> cnt_q == $past(cnt_q) + CW'(1))
    else $error("falling kick cleared rising-only count");

  AST_FILTER_HOLD: assert property (
    @(posedge clock) disable iff (rst)
    (rdy_q[0] && $changed(flt_q[0])) |->
      $past(fc_q[0]) == FILT_M1 && $past(s2_q.kick) == flt_q[0])
    else $error("kick filter passed a short level");

  AST_NO_STARTUP_EDGE: assert property (
    @(posedge clock) disable iff (rst)
    (!arm_q[0] && watching && !hold && !tmo_hit)
      |=> cnt_q == $past(cnt_q) + CW'(1))
    else $error("kick level cleared count during settle");

  AST_PULSE_FULL: assert property (
    @(posedge clock) disable iff (rst)
    (BOTH_EDGE && $rose(alarm_n_q) && !$past(hold)) |->
      $past(cnt_q) == PULSE_M1)
    else $error("both-edge alarm pulse width wrong");

  AST_MIN_LOW: assert property (
    @(posedge clock) disable iff (rst)
    $rose(alarm_n_q) |-> $past(cnt_q) >= LOW_M1)
    else $error("alarm low pulse under 10 us");

  AST_MAX_LOW: assert property (
    @(posedge clock) disable iff (rst)
    (!BOTH_EDGE && !watching && tmo_hit && !hold) |=> alarm_n_q)
    else $error("rising-only alarm held past timeout");

  AST_OUT_LEVEL: assert property (
    @(posedge clock) disable iff (rst)
    (watching && hold) [*2] |-> alarm_n_q)
    else $error("alarm low while hold-off high");

  // reset leaves the alarm released and the count at zero
  AST_RESET_HIGH: assert property (
    @(posedge clock)
    $fell(rst) |-> (alarm_n_q && cnt_q == '0))
    else $error("alarm or count wrong after reset");

  AST_WATCH_COUNTS: assert property (
    @(posedge clock) disable iff (rst)
    (watching && !wd_clr && !tmo_hit) |=> cnt_q == $past(cnt_q) + CW'(1))
    else $error("count did not advance while watching");

  AST_TMO_RESTART: assert property (
    @(posedge clock) disable iff (rst)
    (watching && tmo_hit && !wd_clr) |=> (!alarm_n_q && cnt_q == '0))
    else $error("timeout did not raise the alarm");

  // a kick in the very last cycle still saves the controller
  AST_KICK_AT_TMO: assert property (
    @(posedge clock) disable iff (rst)
    (watching && tmo_hit && wd_clr) |=> alarm_n_q)
    else $error("alarm despite a clear at timeout");

  AST_FALL_CLEARS: assert property (
    @(posedge clock) disable iff (rst)
    (BOTH_EDGE && watching && fall[spwd_pkg::IN_KICK])
      |=> (cnt_q == '0 && alarm_n_q))
    else $error("falling kick did not clear both-edge count");

  AST_PULSE_IGNORES: assert property (
    @(posedge clock) disable iff (rst)
    (BOTH_EDGE && !watching && !hold && !pulse_hit) |=> !alarm_n_q)
    else $error("both-edge alarm pulse cut short");

  AST_RISE_RELEASE: assert property (
    @(posedge clock) disable iff (rst)
    (!BOTH_EDGE && !watching && kick_rise && low_ok) |=> alarm_n_q)
    else $error("rising kick did not release the alarm");

  AST_EARLY_KICK_KEPT: assert property (
    @(posedge clock) disable iff (rst)
    (!BOTH_EDGE && !watching && !low_ok && !tmo_hit) |=> !alarm_n_q)
    else $error("rising-only alarm released under 10 us");

  AST_HOLD_RELEASE: assert property (
    @(posedge clock) disable iff (rst)
    (!watching && hold && low_ok) |=> (alarm_n_q && cnt_q == '0))
    else $error("hold-off did not release the alarm");

  AST_HOLD_MIN_KEPT: assert property (
    @(posedge clock) disable iff (rst)
    (!watching && hold && !low_ok) |=> !alarm_n_q)
    else $error("hold-off released alarm under 10 us");

  AST_HOLD_FILTER: assert property (
    @(posedge clock) disable iff (rst)
    (rdy_q[1] && $changed(flt_q[1])) |->
      $past(fc_q[1]) == FILT_M1 && $past(s2_q.hold) == flt_q[1])
    else $error("hold-off filter passed a short level");

  AST_ALARM_COUNTS: assert property (
    @(posedge clock) disable iff (rst)
    (!watching && !rel_ok)
      |=> (!alarm_n_q && cnt_q == $past(cnt_q) + CW'(1)))
    else $error("alarm interval count did not advance");

endmodule

`default_nettype wire

// *** test/spwd_mcu.sv ***
// controller model that kicks the watchdog pin
`default_nettype none
module spwd_mcu (
  input  wire logic        clock,
  input  wire logic        en,
  input  wire logic [15:0] per,
  input  wire logic [15:0] wid,
  output var  logic        kick_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cnt_q = 16'h0000;
  initial kick_in = 1'b0;
  // idle keeps the last level: a stuck controller
  always @(posedge clock) begin
    if (en) begin
      cnt_q <= #1 (cnt_q + 16'h0001 >= per) ? 16'h0000 : cnt_q + 16'h0001;
      kick_in <= #1 (cnt_q < wid);
    end
  end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for both watchdog variants
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T = 3000;
  localparam int P = 2500;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        hold_in = 1'b0;
  logic        en = 1'b0;
  logic        pick = 1'b0;
  logic [15:0] per = 16'h03e8;
  logic [15:0] wid = 16'h00c8;
  int          fail_count = 0;
  int          checks_done = 0;
  int          n;
  int          nb;
  wire logic   kick_in;
  wire logic   al_a_n;
  wire logic   al_b_n;
  wire logic   al_n = pick ? al_b_n : al_a_n;

  always #2.5 clock = ~clock;

  spwd_mcu mcu (.clock(clock), .en(en), .per(per), .wid(wid),
    .kick_in(kick_in));
  spwd_top #(.TIMEOUT_CYC(T), .PULSE_CYC(P), .BOTH_EDGE(1'b0)) uut (
    .clock(clock), .rst(rst), .kick_in(kick_in), .hold_in(hold_in),
    .alarm_out_n(al_a_n));
  spwd_top #(.TIMEOUT_CYC(T), .PULSE_CYC(P), .BOTH_EDGE(1'b1)) uut_b (
    .clock(clock), .rst(rst), .kick_in(kick_in), .hold_in(hold_in),
    .alarm_out_n(al_b_n));

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input int lo, input int hi,
                     input int seen);
    checks_done++;
    if (seen < lo || seen > hi) begin
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, seen);
      fail_count++;
    end
  endtask
  // cycles until the selected alarm leaves level v
  task automatic run(input logic v, output int k);
    k = 0;
    while (al_n === v && k < 2 * T) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic lows(input int len, output int k, output int kb);
    k = 0;
    kb = 0;
    repeat (len) begin
      cyc(1);
      if (al_a_n !== 1'b1) k++;
      if (al_b_n !== 1'b1) kb++;
    end
  endtask
  task automatic kick(input logic e, input logic [15:0] p,
                      input logic [15:0] w);
    en = e;
    per = p;
    wid = w;
  endtask

  task automatic t_power;
    run(1'b1, n);
    chk("first timeout", T - 3, T + 3, n);
    run(1'b0, n);
    chk("low width", T - 3, T + 3, n);
    run(1'b1, n);
    chk("toggle period", T - 3, T + 3, n);
    $display("test power_up done");
  endtask
  task automatic t_kick;
    kick(1'b1, 16'h03e8, 16'h00c8);
    run(1'b0, n);
    chk("kick release", 2000, T, n);
    lows(4 * T, n, nb);
    chk("kicked lows", 0, 0, n);
    chk("both-edge kicked lows", 0, 0, nb);
    kick(1'b1, 16'h01f4, 16'h000a);
    run(1'b1, n);
    chk("glitch kicks", T - 1200, T + 110, n);
    kick(1'b0, 16'h01f4, 16'h000a);
    run(1'b0, n);
    $display("test kick done");
  endtask
  task automatic t_edges;
    kick(1'b1, 16'h0fa0, 16'h07d0);
    pick = 1'b1;
    cyc(2500);
    run(1'b0, n);
    lows(4 * T, n, nb);
    chk("both-edge lows", 0, 0, nb);
    chk("rising-only lows", 1, 4 * T, n);
    $display("test edges done");
  endtask
  task automatic t_pulse;
    kick(1'b0, 16'h0190, 16'h00c8);
    run(1'b1, n);
    kick(1'b1, 16'h0190, 16'h00c8);
    run(1'b0, n);
    chk("both-edge pulse", P - 3, P + 3, n);
    kick(1'b0, 16'h0190, 16'h00c8);
    run(1'b1, n);
    chk("both-edge period", T - 3, T + 110, n);
    pick = 1'b0;
    $display("test pulse done");
  endtask
  task automatic t_hold;
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
    cyc(500);
    hold_in = 1'b1;
    lows(6000, n, nb);
    chk("held lows", 0, 0, n);
    chk("both-edge held lows", 0, 0, nb);
    hold_in = 1'b0;
    run(1'b1, n);
    chk("after hold", T + 95, T + 110, n);
    cyc(100);
    hold_in = 1'b1;
    run(1'b0, n);
    chk("hold release", 1897, 1903, n);
    hold_in = 1'b0;
    $display("test hold done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    cyc(16);
    rst = 1'b0;
    t_power();
    t_kick();
    t_edges();
    t_pulse();
    t_hold();
    complete_run();
  end
  // whole run is about 63000 cycles
  initial begin
    repeat (95000) @(posedge clock);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
